// ===== rtl/nalu_pkg.sv
// Package with types and constants for the nibble ALU datapath.
package nalu_pkg;

    // ==========================================================
    // Widths
    // ==========================================================
    localparam int NIB_W = 4;
    localparam int ADDR_W = 4;

    // ==========================================================
    // Register map
    // ==========================================================
    localparam logic [ADDR_W-1:0] ADDR_FLAGS = 4'h0;
    localparam logic [ADDR_W-1:0] ADDR_MODE = 4'h1;
    localparam int ZERO_BIT = 1;
    localparam int CARRY_BIT = 2;
    localparam int INHIBIT_BIT = 3;
    localparam int DEC_BIT = 0;
    localparam logic [NIB_W-1:0] RD_NONE = 4'h0;

    // ==========================================================
    // Arithmetic constants
    // ==========================================================
    localparam logic [NIB_W:0] DEC_MAX = 5'h09;
    localparam logic [NIB_W-1:0] DEC_ADJ = 4'h6;
    localparam logic [NIB_W-1:0] NIB_ZERO = 4'h0;
    localparam logic [NIB_W-1:0] NIB_TOP = 4'h0;

    // ==========================================================
    // Operations and carriers
    // ==========================================================
    typedef enum logic [3:0] {
        OP_ADD, OP_ADD_WITH_CARRY, OP_SUB, OP_SUBTRACT_WITH_BORROW,
        OP_OR, OP_AND, OP_XOR,
        OP_SKIP_IF_BITS_SET, OP_SKIP_IF_BITS_CLEAR,
        OP_SKIP_IF_EQUAL, OP_SKIP_IF_NOT_EQUAL,
        OP_SKIP_IF_GREATER_OR_EQUAL, OP_SKIP_IF_LESS_THAN,
        OP_ROTATE_RIGHT_THROUGH_CARRY
    } nalu_op_t;

    // One instruction: mem_imm high selects the memory/immediate form.
    typedef struct packed {
        nalu_op_t op;
        logic mem_imm;
        logic [NIB_W-1:0] reg_val;
        logic [NIB_W-1:0] mem_val;
        logic [NIB_W-1:0] imm;
    } nalu_req_t;

    typedef struct packed {
        logic decimal_flag;
        logic compare_inhibit_flag;
        logic carry_flag;
        logic zero_flag;
    } nalu_flags_t;

    localparam nalu_flags_t FLAGS_RST = '0;

endpackage

// ===== rtl/nalu_datapath.sv
// Nibble ALU datapath with flag register and skip decision.
`timescale 1ns/100ps
// ==============================================================
// Summary of operation
// - Add and subtract, register/memory or memory/immediate.
// - Binary on full nibble, decimal on one digit.
// - Add stores to register or memory by form.
// - Add with carry adds carry flag too.
// - Subtract stores difference by form.
// - Subtract with borrow also removes carry flag.
// - AND, OR, XOR over nibble operands.
// - Logic results go to register or memory.
// - Bits-set test clears inhibit, skips if all set.
// - Bits-clear test clears inhibit, skips if masked zero.
// - Equal tests skip on zero or nonzero difference.
// - Magnitude tests skip on no borrow or borrow.
// - Rotate right through carry into register.
// - Compare inhibit blocks arithmetic stores, flags update.
// - Zero flag follows arithmetic result, sticky-cleared under inhibit.
// - Carry set on carry/borrow; only arithmetic, rotate.
// - Decimal flag selects decimal or binary arithmetic.
// ==============================================================
module nalu_datapath (
    // Clock and reset.
    input wire logic I_CLK,
    input wire logic I_RST_N,
    // Instruction request from the sequencer.
    input wire logic I_REQ_VALID,
    input wire nalu_pkg::nalu_req_t I_REQ,
    // Register port.
    input wire logic [nalu_pkg::ADDR_W-1:0] I_ADDR,
    input wire logic [nalu_pkg::NIB_W-1:0] I_WDATA,
    input wire logic I_WR,
    input wire logic I_RD,
    output logic [nalu_pkg::NIB_W-1:0] O_RDATA,
    // Results toward register file, data memory and sequencer.
    output logic [nalu_pkg::NIB_W-1:0] O_RESULT,
    output logic O_WR_REG,
    output logic O_WR_MEM,
    output logic O_SKIP,
    output nalu_pkg::nalu_flags_t O_FLAGS
);
    import nalu_pkg::*;

    // ==========================================================
    // State
    // ==========================================================
    logic [NIB_W-1:0] result_ff, nxt_result_ff;
    logic [NIB_W-1:0] rdata_ff, nxt_rdata_ff;
    logic wr_reg_ff, nxt_wr_reg_ff;
    logic wr_mem_ff, nxt_wr_mem_ff;
    logic skip_ff, nxt_skip_ff;
    nalu_flags_t flags_ff, nxt_flags_ff;

    // ==========================================================
    // Operand selection and arithmetic
    // ==========================================================
    logic [NIB_W-1:0] opa, opb, masked, arith_res;
    logic [NIB_W:0] sum5, diff5, test_diff5;
    logic cin, arith_cy, is_add, is_sub, is_arith;

    always_comb begin
        // Register/memory form uses reg and mem, otherwise mem and imm.
        opa = I_REQ.mem_imm ? I_REQ.mem_val : I_REQ.reg_val;
        opb = I_REQ.mem_imm ? I_REQ.imm : I_REQ.mem_val;
        is_add = (I_REQ.op == OP_ADD) || (I_REQ.op == OP_ADD_WITH_CARRY);
        is_sub = (I_REQ.op == OP_SUB) || (I_REQ.op == OP_SUBTRACT_WITH_BORROW);
        is_arith = is_add || is_sub;
        cin = ((I_REQ.op == OP_ADD_WITH_CARRY) ||
               (I_REQ.op == OP_SUBTRACT_WITH_BORROW)) && flags_ff.carry_flag;
        sum5 = {1'b0, opa} + {1'b0, opb} + {NIB_TOP, cin};
        diff5 = {1'b0, opa} - {1'b0, opb} - {NIB_TOP, cin};
        test_diff5 = {1'b0, I_REQ.mem_val} - {1'b0, I_REQ.imm};
        masked = I_REQ.mem_val & I_REQ.imm;
        if (is_add) begin
            if (flags_ff.decimal_flag && (sum5 > DEC_MAX)) begin
                // Decimal digit correction on overflow past nine.
                arith_res = sum5[NIB_W-1:0] + DEC_ADJ;
                arith_cy = 1'b1;
            end else begin
                arith_res = sum5[NIB_W-1:0];
                arith_cy = sum5[NIB_W];
            end
        end else begin
            if (flags_ff.decimal_flag && diff5[NIB_W]) begin
                arith_res = diff5[NIB_W-1:0] - DEC_ADJ;
            end else begin
                arith_res = diff5[NIB_W-1:0];
            end
            arith_cy = diff5[NIB_W];
        end
    end

    // ==========================================================
    // Next-state logic
    // ==========================================================
    always_comb begin
        nxt_result_ff = result_ff;
        nxt_wr_reg_ff = 1'b0;
        nxt_wr_mem_ff = 1'b0;
        nxt_skip_ff = 1'b0;
        nxt_flags_ff = flags_ff;
        nxt_rdata_ff = RD_NONE;
        // Software access; an instruction in the same cycle wins on flags.
        if (I_WR && (I_ADDR == ADDR_FLAGS)) begin
            nxt_flags_ff.zero_flag = I_WDATA[ZERO_BIT];
            nxt_flags_ff.carry_flag = I_WDATA[CARRY_BIT];
            nxt_flags_ff.compare_inhibit_flag = I_WDATA[INHIBIT_BIT];
        end
        if (I_WR && (I_ADDR == ADDR_MODE)) begin
            nxt_flags_ff.decimal_flag = I_WDATA[DEC_BIT];
        end
        if (I_RD && (I_ADDR == ADDR_FLAGS)) begin
            nxt_rdata_ff = RD_NONE;
            nxt_rdata_ff[ZERO_BIT] = flags_ff.zero_flag;
            nxt_rdata_ff[CARRY_BIT] = flags_ff.carry_flag;
            nxt_rdata_ff[INHIBIT_BIT] = flags_ff.compare_inhibit_flag;
        end
        if (I_RD && (I_ADDR == ADDR_MODE)) begin
            nxt_rdata_ff[DEC_BIT] = flags_ff.decimal_flag;
        end
        if (I_REQ_VALID) begin
            case (I_REQ.op)
                OP_ADD, OP_ADD_WITH_CARRY, OP_SUB, OP_SUBTRACT_WITH_BORROW: begin
                    nxt_result_ff = arith_res;
                    // Inhibit suppresses the store, never the flag update.
                    nxt_wr_reg_ff = !flags_ff.compare_inhibit_flag && !I_REQ.mem_imm;
                    nxt_wr_mem_ff = !flags_ff.compare_inhibit_flag && I_REQ.mem_imm;
                    nxt_flags_ff.carry_flag = arith_cy;
                    if (flags_ff.compare_inhibit_flag) begin
                        nxt_flags_ff.zero_flag = flags_ff.zero_flag &&
                                                 (arith_res == NIB_ZERO);
                    end else begin
                        nxt_flags_ff.zero_flag = (arith_res == NIB_ZERO);
                    end
                end
                OP_OR, OP_AND, OP_XOR: begin
                    if (I_REQ.op == OP_OR) begin
                        nxt_result_ff = opa | opb;
                    end else if (I_REQ.op == OP_AND) begin
                        nxt_result_ff = opa & opb;
                    end else begin
                        nxt_result_ff = opa ^ opb;
                    end
                    nxt_wr_reg_ff = !I_REQ.mem_imm;
                    nxt_wr_mem_ff = I_REQ.mem_imm;
                end
                OP_SKIP_IF_BITS_SET: begin
                    nxt_flags_ff.compare_inhibit_flag = 1'b0;
                    nxt_skip_ff = (masked == I_REQ.imm);
                end
                OP_SKIP_IF_BITS_CLEAR: begin
                    nxt_flags_ff.compare_inhibit_flag = 1'b0;
                    nxt_skip_ff = (masked == NIB_ZERO);
                end
                OP_SKIP_IF_EQUAL: begin
                    nxt_skip_ff = (test_diff5[NIB_W-1:0] == NIB_ZERO);
                end
                OP_SKIP_IF_NOT_EQUAL: begin
                    nxt_skip_ff = (test_diff5[NIB_W-1:0] != NIB_ZERO);
                end
                OP_SKIP_IF_GREATER_OR_EQUAL: begin
                    nxt_skip_ff = !test_diff5[NIB_W];
                end
                OP_SKIP_IF_LESS_THAN: begin
                    nxt_skip_ff = test_diff5[NIB_W];
                end
                OP_ROTATE_RIGHT_THROUGH_CARRY: begin
                    nxt_result_ff = {flags_ff.carry_flag,
                                     I_REQ.reg_val[NIB_W-1:1]};
                    nxt_flags_ff.carry_flag = I_REQ.reg_val[0];
                    nxt_wr_reg_ff = 1'b1;
                end
                default: begin
                    nxt_result_ff = result_ff;
                end
            endcase
        end
    end

    always_ff @(posedge I_CLK) begin
        if (!I_RST_N) begin
            result_ff <= NIB_ZERO;
            rdata_ff <= RD_NONE;
            wr_reg_ff <= 1'b0;
            wr_mem_ff <= 1'b0;
            skip_ff <= 1'b0;
            flags_ff <= FLAGS_RST;
        end else begin
            result_ff <= nxt_result_ff;
            rdata_ff <= nxt_rdata_ff;
            wr_reg_ff <= nxt_wr_reg_ff;
            wr_mem_ff <= nxt_wr_mem_ff;
            skip_ff <= nxt_skip_ff;
            flags_ff <= nxt_flags_ff;
        end
    end

    assign O_RESULT = result_ff;
    assign O_RDATA = rdata_ff;
    assign O_WR_REG = wr_reg_ff;
    assign O_WR_MEM = wr_mem_ff;
    assign O_SKIP = skip_ff;
    assign O_FLAGS = flags_ff;

    // ==========================================================
    // Checks
    // ==========================================================
    default clocking cb @(posedge I_CLK); endclocking
    default disable iff (!I_RST_N);

    arith_store_a: assert property (I_REQ_VALID && is_arith && !I_REQ.mem_imm &&
        !flags_ff.compare_inhibit_flag |=> O_WR_REG && !O_WR_MEM)
        else $error("arithmetic register form did not store");

    inhibit_store_a: assert property (I_REQ_VALID && is_arith &&
        flags_ff.compare_inhibit_flag |=> !O_WR_REG && !O_WR_MEM)
        else $error("store seen while compare inhibit set");

    zero_flag_a: assert property (I_REQ_VALID && is_arith &&
        !flags_ff.compare_inhibit_flag |=> O_FLAGS.zero_flag == (O_RESULT == NIB_ZERO))
        else $error("zero flag does not match result");

    bit_test_a: assert property (I_REQ_VALID && ((I_REQ.op == OP_SKIP_IF_BITS_SET) ||
        (I_REQ.op == OP_SKIP_IF_BITS_CLEAR)) |=> !O_FLAGS.compare_inhibit_flag &&
        !O_WR_REG && !O_WR_MEM)
        else $error("bit test left inhibit set or stored");

    carry_keep_a: assert property (I_REQ_VALID && !is_arith && !I_WR &&
        (I_REQ.op != OP_ROTATE_RIGHT_THROUGH_CARRY) |=> $stable(O_FLAGS.carry_flag))
        else $error("carry changed by non-arithmetic operation");

    rotate_res_a: assert property (I_REQ_VALID &&
        (I_REQ.op == OP_ROTATE_RIGHT_THROUGH_CARRY) |=>
        O_RESULT == {$past(flags_ff.carry_flag), $past(I_REQ.reg_val[NIB_W-1:1])} &&
        O_FLAGS.carry_flag == $past(I_REQ.reg_val[0]) && O_WR_REG)
        else $error("rotate result or carry wrong");

    skip_equal_a: assert property (I_REQ_VALID && (I_REQ.op == OP_SKIP_IF_EQUAL) |=>
        O_SKIP == ($past(I_REQ.mem_val) == $past(I_REQ.imm)))
        else $error("equal skip decision wrong");

    skip_pulse_a: assert property (O_SKIP |-> $past(I_REQ_VALID) &&
        !O_WR_REG && !O_WR_MEM)
        else $error("skip pulse without a test instruction");

    dec_digit_a: assert property (I_REQ_VALID && is_add && flags_ff.decimal_flag &&
        (opa <= DEC_MAX[NIB_W-1:0]) && (opb <= DEC_MAX[NIB_W-1:0]) |=>
        O_RESULT <= DEC_MAX[NIB_W-1:0])
        else $error("decimal addition left a non-digit result");

    mem_store_a: assert property (I_REQ_VALID && is_arith && I_REQ.mem_imm &&
        !flags_ff.compare_inhibit_flag |=> O_WR_MEM && !O_WR_REG)
        else $error("arithmetic memory form did not store");

    binary_add_a: assert property (I_REQ_VALID && (I_REQ.op == OP_ADD) &&
        !flags_ff.decimal_flag |=> {O_FLAGS.carry_flag, O_RESULT} ==
        $past({1'b0, I_REQ.mem_val} + {1'b0, (I_REQ.mem_imm ? I_REQ.imm : I_REQ.reg_val)}))
        else $error("binary sum or carry wrong");

    zero_keep_a: assert property (I_REQ_VALID && is_arith &&
        flags_ff.compare_inhibit_flag |=>
        O_FLAGS.zero_flag == ($past(flags_ff.zero_flag) && (O_RESULT == NIB_ZERO)))
        else $error("zero flag under inhibit wrong");

    logic_store_a: assert property (I_REQ_VALID &&
        ((I_REQ.op == OP_OR) || (I_REQ.op == OP_AND) || (I_REQ.op == OP_XOR)) |=>
        (O_WR_MEM == $past(I_REQ.mem_imm)) && (O_WR_REG == !$past(I_REQ.mem_imm)))
        else $error("logic result sent to wrong place");

    xor_result_a: assert property (I_REQ_VALID && (I_REQ.op == OP_XOR) |=>
        O_RESULT == ($past(I_REQ.mem_val) ^
        ($past(I_REQ.mem_imm) ? $past(I_REQ.imm) : $past(I_REQ.reg_val))))
        else $error("exclusive-or result wrong");

    logic_flags_a: assert property (I_REQ_VALID && !I_WR &&
        ((I_REQ.op == OP_OR) || (I_REQ.op == OP_AND) || (I_REQ.op == OP_XOR)) |=>
        $stable(O_FLAGS))
        else $error("logic operation changed a flag");

    bits_set_skip_a: assert property (I_REQ_VALID &&
        (I_REQ.op == OP_SKIP_IF_BITS_SET) |=>
        O_SKIP == (($past(I_REQ.mem_val) & $past(I_REQ.imm)) == $past(I_REQ.imm)))
        else $error("bits-set skip decision wrong");

    bits_clear_skip_a: assert property (I_REQ_VALID &&
        (I_REQ.op == OP_SKIP_IF_BITS_CLEAR) |=>
        O_SKIP == (($past(I_REQ.mem_val) & $past(I_REQ.imm)) == NIB_ZERO))
        else $error("bits-clear skip decision wrong");

    skip_unequal_a: assert property (I_REQ_VALID &&
        (I_REQ.op == OP_SKIP_IF_NOT_EQUAL) |=>
        O_SKIP == ($past(I_REQ.mem_val) != $past(I_REQ.imm)))
        else $error("not-equal skip decision wrong");

    skip_ge_a: assert property (I_REQ_VALID &&
        (I_REQ.op == OP_SKIP_IF_GREATER_OR_EQUAL) |=>
        O_SKIP == ($past(I_REQ.mem_val) >= $past(I_REQ.imm)))
        else $error("greater-or-equal skip decision wrong");

    skip_lt_a: assert property (I_REQ_VALID &&
        (I_REQ.op == OP_SKIP_IF_LESS_THAN) |=>
        O_SKIP == ($past(I_REQ.mem_val) < $past(I_REQ.imm)))
        else $error("less-than skip decision wrong");

    compare_quiet_a: assert property (I_REQ_VALID && !I_WR &&
        (I_REQ.op inside {OP_SKIP_IF_EQUAL, OP_SKIP_IF_NOT_EQUAL,
        OP_SKIP_IF_GREATER_OR_EQUAL, OP_SKIP_IF_LESS_THAN}) |=>
        $stable(O_FLAGS) && !O_WR_REG && !O_WR_MEM)
        else $error("comparison changed a flag or stored");

    skip_other_a: assert property (I_REQ_VALID && (is_arith ||
        (I_REQ.op == OP_ROTATE_RIGHT_THROUGH_CARRY)) |=> !O_SKIP)
        else $error("skip raised by a non-test instruction");

endmodule

// ===== dv/nalu_partner.sv
// Far-side model holding the general register written by the datapath.
`timescale 1ns/100ps
module nalu_partner (
    // Clock and reset.
    input wire logic i_clk,
    input wire logic i_rst_n,
    // Result and register write strobe from the datapath.
    input wire logic [3:0] i_result,
    input wire logic i_wr_reg,
    // General register value offered as the next operand.
    output logic [3:0] o_gen_reg
);
    logic [3:0] gen_reg_ff;
    // A write in flight is forwarded so back-to-back instructions see it.
    assign o_gen_reg = i_wr_reg ? i_result : gen_reg_ff;
    always_ff @(posedge i_clk) begin
        if (!i_rst_n) begin
            gen_reg_ff <= 4'h0;
        end else if (i_wr_reg) begin
            gen_reg_ff <= i_result;
        end
    end
endmodule

// ===== dv/nalu_tb.sv
// Self-checking testbench for the nibble ALU datapath.
`timescale 1ns/100ps
`define CHK(got, exp, what) begin comparisons++; if ((got) !== (exp)) begin n_mismatch++; \
    $display("ERROR %0t ns: %s got %h expected %h", $time, what, got, exp); end end
module testbench;
    import nalu_pkg::*;
    typedef struct packed {
        logic rd;
        logic [3:0] rdata;
        logic [3:0] res;
        logic wreg;
        logic wmem;
        logic skip;
        nalu_flags_t fl;
    } nalu_note_t;
    logic clk = 1'b0, rst_n = 1'b0, req_valid = 1'b0, req_mi = 1'b0, wr = 1'b0, rd = 1'b0;
    logic v_d = 1'b0, r_d = 1'b0, o_wr_reg, o_wr_mem, o_skip;
    nalu_op_t req_op = OP_ADD;
    logic [3:0] req_mem = 4'h0, req_imm = 4'h0, addr = 4'h0, wdata = 4'h0;
    logic [3:0] gen_reg, o_rdata, o_result, exp_reg = 4'h0;
    nalu_flags_t o_flags, exp_flags = FLAGS_RST;
    nalu_req_t dut_req;
    nalu_note_t notes[$];
    int n_mismatch = 0, comparisons = 0;
    assign dut_req = '{op: req_op, mem_imm: req_mi, reg_val: gen_reg, mem_val: req_mem,
                       imm: req_imm};
    always #50 clk = ~clk;
    nalu_datapath i_dut (.I_CLK(clk), .I_RST_N(rst_n), .I_REQ_VALID(req_valid),
        .I_REQ(dut_req), .I_ADDR(addr), .I_WDATA(wdata), .I_WR(wr), .I_RD(rd),
        .O_RDATA(o_rdata), .O_RESULT(o_result), .O_WR_REG(o_wr_reg), .O_WR_MEM(o_wr_mem),
        .O_SKIP(o_skip), .O_FLAGS(o_flags));
    nalu_partner i_partner (.i_clk(clk), .i_rst_n(rst_n), .i_result(o_result),
        .i_wr_reg(o_wr_reg), .o_gen_reg(gen_reg));
    // ==========================================================
    // Drivers
    // ==========================================================
    task automatic do_op(input nalu_op_t op, input logic mi, input logic [3:0] mv, iv);
        logic [3:0] a, b;
        logic [4:0] s;
        logic cin, ar;
        nalu_note_t n;
        a = mi ? mv : exp_reg;
        b = mi ? iv : mv;
        n = '0;
        n.fl = exp_flags;
        ar = (op inside {OP_ADD, OP_ADD_WITH_CARRY, OP_SUB, OP_SUBTRACT_WITH_BORROW});
        cin = (op inside {OP_ADD_WITH_CARRY, OP_SUBTRACT_WITH_BORROW}) & exp_flags.carry_flag;
        s = 5'h00;
        case (op)
            OP_ADD, OP_ADD_WITH_CARRY: begin
                s = {1'b0, a} + {1'b0, b} + {4'h0, cin};
                if (exp_flags.decimal_flag && s > 5'h09) s = (s + 5'h06) | 5'h10;
            end
            OP_SUB, OP_SUBTRACT_WITH_BORROW: begin
                s = {1'b0, a} - {1'b0, b} - {4'h0, cin};
                if (exp_flags.decimal_flag && s[4]) s[3:0] = s[3:0] - 4'h6;
            end
            OP_OR: n.res = a | b;
            OP_AND: n.res = a & b;
            OP_XOR: n.res = a ^ b;
            OP_SKIP_IF_BITS_SET: n.skip = ((mv & iv) == iv);
            OP_SKIP_IF_BITS_CLEAR: n.skip = ((mv & iv) == 4'h0);
            OP_SKIP_IF_EQUAL: n.skip = (mv == iv);
            OP_SKIP_IF_NOT_EQUAL: n.skip = (mv != iv);
            OP_SKIP_IF_GREATER_OR_EQUAL: n.skip = (mv >= iv);
            OP_SKIP_IF_LESS_THAN: n.skip = (mv < iv);
            default: begin
                n.res = {exp_flags.carry_flag, exp_reg[3:1]};
                n.fl.carry_flag = exp_reg[0];
            end
        endcase
        if (op inside {OP_SKIP_IF_BITS_SET, OP_SKIP_IF_BITS_CLEAR}) n.fl.compare_inhibit_flag = 1'b0;
        n.wreg = !mi && (op inside {OP_OR, OP_AND, OP_XOR}) || op == OP_ROTATE_RIGHT_THROUGH_CARRY;
        n.wmem = mi && (op inside {OP_OR, OP_AND, OP_XOR});
        if (ar) begin
            n.res = s[3:0];
            n.fl.carry_flag = s[4];
            n.fl.zero_flag = (s[3:0] == 4'h0) && (!exp_flags.compare_inhibit_flag || exp_flags.zero_flag);
            n.wreg = !exp_flags.compare_inhibit_flag && !mi;
            n.wmem = !exp_flags.compare_inhibit_flag && mi;
        end
        if (n.wreg) exp_reg = n.res;
        exp_flags = n.fl;
        notes.push_back(n);
        @(posedge clk);
        {wr, rd, req_valid} <= 3'h1;
        req_op <= op;
        req_mi <= mi;
        req_mem <= mv;
        req_imm <= iv;
    endtask
    task automatic reg_wr(input logic [3:0] a, input logic [3:0] d);
        @(posedge clk);
        {wr, rd, req_valid} <= 3'h4;
        addr <= a;
        wdata <= d;
        if (a == ADDR_FLAGS) {exp_flags.compare_inhibit_flag, exp_flags.carry_flag,
            exp_flags.zero_flag} = d[3:1];
        if (a == ADDR_MODE) exp_flags.decimal_flag = d[0];
    endtask
    task automatic reg_rd(input logic [3:0] a);
        nalu_note_t n;
        n = '0;
        n.rd = 1'b1;
        if (a == ADDR_FLAGS) n.rdata = {exp_flags.compare_inhibit_flag, exp_flags.carry_flag,
            exp_flags.zero_flag, 1'b0};
        if (a == ADDR_MODE) n.rdata = {3'h0, exp_flags.decimal_flag};
        notes.push_back(n);
        @(posedge clk);
        {wr, rd, req_valid} <= 3'h2;
        addr <= a;
    endtask
    task automatic close_out();
        $display("Comparisons %0d, mismatches %0d", comparisons, n_mismatch);
        if (n_mismatch == 0 && comparisons > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask
    // ==========================================================
    // Monitor
    // ==========================================================
    always @(posedge clk) begin
        v_d <= req_valid;
        r_d <= rd;
    end
    always @(negedge clk) begin
        nalu_note_t n;
        if ((v_d || r_d) && notes.size() > 0) begin
            n = notes.pop_front();
            if (n.rd) begin
                `CHK(o_rdata, n.rdata, "read data");
            end else begin
                `CHK({o_wr_reg, o_wr_mem}, {n.wreg, n.wmem}, "stores");
                if (n.wreg || n.wmem) `CHK(o_result, n.res, "result");
                `CHK(o_skip, n.skip, "skip");
                `CHK(o_flags, n.fl, "flags");
            end
        end else begin
            `CHK({o_wr_reg, o_wr_mem, o_skip, o_rdata}, 7'h00, "idle outputs");
        end
    end
    initial begin
        repeat (5000) @(posedge clk);
        n_mismatch++;
        $display("ERROR %0t ns: watchdog expired", $time);
        close_out();
    end
    // ==========================================================
    // Tests
    // ==========================================================
    initial begin
        int k;
        k = $urandom(32'h40F8);
        repeat (12) @(posedge clk);
        rst_n <= 1'b1;
        reg_rd(ADDR_FLAGS);
        reg_rd(ADDR_MODE);
        reg_rd(4'h7);
        do_op(OP_OR, 1'b0, 4'h3, 4'h0);
        do_op(OP_ADD, 1'b0, 4'h4, 4'h0);
        reg_wr(ADDR_FLAGS, 4'hA);
        do_op(OP_SUB, 1'b1, 4'h4, 4'h4);
        do_op(OP_SUB, 1'b1, 4'h5, 4'h5);
        do_op(OP_SUB, 1'b1, 4'h6, 4'h7);
        do_op(OP_SKIP_IF_BITS_SET, 1'b1, 4'h0, 4'h0);
        for (int i = 0; i < 300; i++) begin
            k = $urandom_range(0, 9);
            if (k == 0) reg_wr(ADDR_FLAGS, 4'($urandom_range(0, 15)));
            else if (k == 1) reg_rd(4'($urandom_range(0, 3)));
            else do_op(nalu_op_t'(4'($urandom_range(0, 13))), 1'($urandom_range(0, 1)),
                4'($urandom), 4'($urandom));
        end
        do_op(OP_AND, 1'b0, 4'h0, 4'h0);
        do_op(OP_OR, 1'b0, 4'h9, 4'h0);
        reg_wr(ADDR_MODE, 4'h1);
        for (int i = 0; i < 200; i++) begin
            k = $urandom_range(0, 9);
            if (k == 0) reg_wr(ADDR_FLAGS, 4'($urandom_range(0, 15)));
            else if (k == 1) reg_rd(4'($urandom_range(0, 3)));
            else do_op(nalu_op_t'(4'(k < 6 ? k - 2 : k + 3)), 1'($urandom_range(0, 1)),
                4'($urandom_range(0, 9)), 4'($urandom_range(0, 9)));
        end
        @(posedge clk);
        {wr, rd, req_valid} <= 3'h0;
        repeat (3) @(posedge clk);
        close_out();
    end
endmodule
